// ---- pkg/pitlv_pkg.sv ----
// constants for the periodic timer and low-voltage monitor block
package pitlv_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [15:0] LOW_VOLTAGE_CONTROL_OFS    = 16'h02f1;
  localparam logic [15:0] PERIODIC_TIMER_CONTROL_OFS = 16'h02f2;
  localparam logic [15:0] PERIODIC_CLOCK_TRIM_OFS    = 16'h02f3;
  localparam logic [15:0] PERIODIC_RATE_HIGH_OFS     = 16'h02f4;
  localparam logic [15:0] PERIODIC_RATE_LOW_OFS      = 16'h02f5;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LV_STATUS_BIT  = 2;
  localparam int LV_IRQ_EN_BIT  = 1;
  localparam int LV_FLAG_BIT    = 0;
  localparam int PT_CLKSEL_BIT  = 7;
  localparam int PT_WAVESEL_BIT = 4;
  localparam int PT_PINEN_BIT   = 3;
  localparam int PT_FEAT_BIT    = 2;
  localparam int PT_IRQ_EN_BIT  = 1;
  localparam int PT_FLAG_BIT    = 0;
  localparam int TRIM_W         = 6;
  localparam int RATE_W         = 16;
  localparam int COUNT_W        = 17;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [5:0]  TRIM_RESET = 6'h00;

  // ----------------------------------------
  // low-power clock timing
  // ----------------------------------------
  localparam int CLOCK_HZ           = 10_000_000;
  localparam int LP_CLOCK_PERIOD_US = 100;
  localparam int LP_BASE_CYCLES     = (LP_CLOCK_PERIOD_US * (CLOCK_HZ / 1_000_000));
  localparam int LP_TRIM_STEP       = 4;
  localparam int LP_DIV_W           = 12;

endpackage

// ---- src/pitlv_timer.sv ----
// periodic interrupt timer with low-voltage status and flag logic
`timescale 1ns/10ps
`default_nettype none

// How it works
// [RQ1] status follows supply comparator, read only
// [RQ2] status 0 above release, 1 below assert
// [RQ3] any status change sets flag
// [RQ4] flag cleared only by writing one
// [RQ5] low-voltage request while flag and enable
// [RQ6] bit 7: 0 low-power clock, 1 bus
// [RQ7] clock select writable only while disabled
// [RQ8] feature enable starts timer, clear disables
// [RQ9] pin pulse half minimum period per period
// [RQ10] pin square clock at twice the period
// [RQ11] pin driven only with pin and feature enables
// [RQ12] timeout flag set at each period end
// [RQ13] timeout flag write-one-clear, enable requests
// [RQ14] periodic request only when enable is one
// [RQ15] six-bit signed trim adjusts low-power clock
// [RQ16] bit 5 lengthens, lower bits shorten less
// [RQ17] trim loaded from nonvolatile value after reset
// [RQ18] rate bytes writable only while disabled
// [RQ19] period is two times rate plus one
// [RQ20] waveform select 0 pulse, 1 square
// [RQ21] counter reloads, clearing enable resets it
// [RQ22] change detect against previous status
module pitlv_timer
  import pitlv_pkg::*;
(
  input  wire logic              clock,                     // 10 MHz bus clock
  input  wire logic              reset_n,                   // asynchronous system reset
  input  wire logic [ADDR_W-1:0] reg_addr,                  // register address
  input  wire logic [DATA_W-1:0] reg_wdata,                 // register write data
  input  wire logic              reg_write,                 // write strobe
  input  wire logic              reg_read,                  // read strobe
  output logic      [DATA_W-1:0] reg_rdata,                 // read data, cycle after strobe
  input  wire logic              monitored_supply_low,      // comparator: supply below threshold
  input  wire logic [TRIM_W-1:0] nvm_trim_value,            // trim value from nonvolatile memory
  output logic                   supply_low_irq,            // low-voltage interrupt request
  output logic                   periodic_irq,              // periodic interrupt request
  output logic                   periodic_waveform_pin      // external timer waveform
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // low-power clock divider length; bit 5 adds, lower bits subtract
  function automatic logic [LP_DIV_W-1:0] lp_cycles(input logic [TRIM_W-1:0] t);
    int v;
    v = LP_BASE_CYCLES + (t[5] ? 32 * LP_TRIM_STEP : 0) - int'(t[4:0]) * LP_TRIM_STEP;
    lp_cycles = LP_DIV_W'(v);
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0]          sync_reg;
  logic                lv_status_reg;
  logic                lv_irq_en_reg;
  logic                lv_flag_reg;
  logic                clksel_reg;
  logic                wavesel_reg;
  logic                pinen_reg;
  logic                feat_reg;
  logic                pt_irq_en_reg;
  logic                pt_flag_reg;
  logic [TRIM_W-1:0]   trim_reg;
  logic                trim_load_reg;
  logic [RATE_W-1:0]   rate_reg;
  logic [LP_DIV_W-1:0] lp_div_reg;
  logic [COUNT_W-1:0]  count_reg;
  logic                pulse_reg;
  logic                square_reg;
  logic                pin_reg;
  logic [DATA_W-1:0]   rdata_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_lv    = reg_write && addr_is(reg_addr, LOW_VOLTAGE_CONTROL_OFS);
  wire wr_ctl   = reg_write && addr_is(reg_addr, PERIODIC_TIMER_CONTROL_OFS);
  wire wr_trim  = reg_write && addr_is(reg_addr, PERIODIC_CLOCK_TRIM_OFS);
  wire wr_rateh = reg_write && addr_is(reg_addr, PERIODIC_RATE_HIGH_OFS);
  wire wr_ratel = reg_write && addr_is(reg_addr, PERIODIC_RATE_LOW_OFS);

  // [RQ2] agreed comparator level; only stages two and three are compared
  wire supply_stable = (sync_reg[1] == sync_reg[2]);
  // [RQ22] change against previous status
  wire lv_change     = supply_stable && (sync_reg[2] != lv_status_reg);

  // [RQ6] tick source select
  wire lp_tick   = (lp_div_reg == '0);
  wire src_tick  = clksel_reg ? 1'b1 : lp_tick;
  // [RQ19] last count is 2*(rate+1)-1
  wire [COUNT_W-1:0] last_count = {rate_reg, 1'b1};
  wire timeout   = feat_reg && src_tick && (count_reg == last_count);

  // [RQ7] clock select locked while enabled or being enabled
  wire clksel_wr = wr_ctl && !feat_reg && !reg_wdata[PT_FEAT_BIT];
  // [RQ18] rate locked while enabled
  wire rate_wr_ok = !feat_reg;

  wire [DATA_W-1:0] lv_read  = {5'b00000, lv_status_reg, lv_irq_en_reg, lv_flag_reg};
  wire [DATA_W-1:0] ctl_read = {clksel_reg, 2'b00, wavesel_reg, pinen_reg, feat_reg,
                                pt_irq_en_reg, pt_flag_reg};
  wire [DATA_W-1:0] rd_mux   =
      addr_is(reg_addr, LOW_VOLTAGE_CONTROL_OFS)    ? lv_read :
      addr_is(reg_addr, PERIODIC_TIMER_CONTROL_OFS) ? ctl_read :
      addr_is(reg_addr, PERIODIC_CLOCK_TRIM_OFS)    ? {2'b00, trim_reg} :
      addr_is(reg_addr, PERIODIC_RATE_HIGH_OFS)     ? rate_reg[15:8] :
      addr_is(reg_addr, PERIODIC_RATE_LOW_OFS)      ? rate_reg[7:0] : 8'h00;

  // ----------------------------------------
  // low-voltage monitor
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], monitored_supply_low};
    end
  end

  // [RQ1] status updates from the comparator only; bus writes never reach it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lv_status_reg <= 1'b0;
    end else if (lv_change) begin
      lv_status_reg <= sync_reg[2];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lv_irq_en_reg <= 1'b0;
      lv_flag_reg   <= 1'b0;
    end else begin
      if (wr_lv) begin
        lv_irq_en_reg <= reg_wdata[LV_IRQ_EN_BIT];
      end
      // [RQ3] set wins over a clear in the same cycle
      if (lv_change) begin
        lv_flag_reg <= 1'b1;
      // [RQ4] write one clears
      end else if (wr_lv && reg_wdata[LV_FLAG_BIT]) begin
        lv_flag_reg <= 1'b0;
      end
    end
  end

  // [RQ5] low-voltage request
  assign supply_low_irq = lv_flag_reg && lv_irq_en_reg;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clksel_reg    <= CTRL_RESET[PT_CLKSEL_BIT];
      wavesel_reg   <= CTRL_RESET[PT_WAVESEL_BIT];
      pinen_reg     <= CTRL_RESET[PT_PINEN_BIT];
      feat_reg      <= CTRL_RESET[PT_FEAT_BIT];
      pt_irq_en_reg <= CTRL_RESET[PT_IRQ_EN_BIT];
    end else if (wr_ctl) begin
      // [RQ7] guarded clock select
      if (clksel_wr) begin
        clksel_reg <= reg_wdata[PT_CLKSEL_BIT];
      end
      wavesel_reg   <= reg_wdata[PT_WAVESEL_BIT];
      pinen_reg     <= reg_wdata[PT_PINEN_BIT];
      // [RQ8] feature enable
      feat_reg      <= reg_wdata[PT_FEAT_BIT];
      pt_irq_en_reg <= reg_wdata[PT_IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pt_flag_reg <= 1'b0;
    // [RQ12] timeout sets, winning over a clear
    end else if (timeout) begin
      pt_flag_reg <= 1'b1;
    // [RQ13] write one clears
    end else if (wr_ctl && reg_wdata[PT_FLAG_BIT]) begin
      pt_flag_reg <= 1'b0;
    end
  end

  // [RQ14] periodic request gated by enable
  assign periodic_irq = pt_flag_reg && pt_irq_en_reg;

  // ----------------------------------------
  // trim and rate
  // ----------------------------------------
  // trim load waits one edge after release so the nvm word is sampled clocked
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trim_reg      <= TRIM_RESET;
      trim_load_reg <= 1'b1;
    end else if (trim_load_reg) begin
      // [RQ17] nonvolatile load
      trim_reg      <= nvm_trim_value;
      trim_load_reg <= 1'b0;
    end else if (wr_trim) begin
      trim_reg <= reg_wdata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_reg <= RATE_RESET;
    end else if (rate_wr_ok) begin
      // [RQ18] byte writes while disabled
      if (wr_rateh) begin
        rate_reg[15:8] <= reg_wdata;
      end
      if (wr_ratel) begin
        rate_reg[7:0] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // low-power clock and counter
  // ----------------------------------------
  // [RQ15] trimmed divider; restart on enable so the first tick is a full period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lp_div_reg <= '0;
    end else if (!feat_reg || lp_tick) begin
      // [RQ16] signed trim weights
      lp_div_reg <= lp_cycles(trim_reg) - LP_DIV_W'(1);
    end else begin
      lp_div_reg <= lp_div_reg - LP_DIV_W'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    // [RQ21] disabled counter held at zero
    end else if (!feat_reg) begin
      count_reg <= '0;
    end else if (src_tick) begin
      // [RQ21] reload at timeout
      count_reg <= timeout ? '0 : count_reg + COUNT_W'(1);
    end
  end

  // ----------------------------------------
  // external waveform
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_reg  <= 1'b0;
      square_reg <= 1'b0;
    end else if (!feat_reg) begin
      pulse_reg  <= 1'b0;
      square_reg <= 1'b0;
    end else begin
      // [RQ9] pulse lasts one source tick, half the minimum period
      if (timeout) begin
        pulse_reg <= 1'b1;
      end else if (src_tick) begin
        pulse_reg <= 1'b0;
      end
      // [RQ10] toggle per period gives twice the period
      if (timeout) begin
        square_reg <= !square_reg;
      end
    end
  end

  // [RQ20] waveform select; [RQ11] pin gating
  wire pin_next = pinen_reg && feat_reg && (wavesel_reg ? square_reg : pulse_reg);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign periodic_waveform_pin = pin_reg;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

`default_nettype wire

// ---- tb/pitlv_timer_props.sv ----
// bound checker for the periodic timer and low-voltage block
`timescale 1ns/10ps
`default_nettype none
module pitlv_timer_props
  import pitlv_pkg::*;
(
  input wire logic              clock,                 // bus clock
  input wire logic              reset_n,               // async reset
  input wire logic [ADDR_W-1:0] reg_addr,              // address
  input wire logic [DATA_W-1:0] reg_wdata,             // write data
  input wire logic              reg_write,             // write strobe
  input wire logic              reg_read,              // read strobe
  input wire logic [DATA_W-1:0] reg_rdata,             // read data
  input wire logic              monitored_supply_low,  // comparator
  input wire logic [TRIM_W-1:0] nvm_trim_value,        // trim source
  input wire logic              supply_low_irq,        // lv request
  input wire logic              periodic_irq,          // timer request
  input wire logic              periodic_waveform_pin  // waveform
);
  // ----------------------------------------
  // shadow of enables, from bus writes only
  // ----------------------------------------
  logic lv_en_reg, pt_ie_reg, feat_reg, pinen_reg;
  wire  lv_wr = reg_write && reg_addr == LOW_VOLTAGE_CONTROL_OFS;
  wire  pt_wr = reg_write && reg_addr == PERIODIC_TIMER_CONTROL_OFS;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lv_en_reg <= 1'b0;
      pt_ie_reg <= 1'b0;
      feat_reg  <= 1'b0;
      pinen_reg <= 1'b0;
    end else begin
      if (lv_wr) lv_en_reg <= reg_wdata[LV_IRQ_EN_BIT];
      if (pt_wr) pt_ie_reg <= reg_wdata[PT_IRQ_EN_BIT];
      if (pt_wr) feat_reg <= reg_wdata[PT_FEAT_BIT];
      if (pt_wr) pinen_reg <= reg_wdata[PT_PINEN_BIT];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_lv_reserved: assert property (reg_read && lv_wr == 1'b0 && reg_addr == LOW_VOLTAGE_CONTROL_OFS
    |=> reg_rdata[7:3] == 5'h00) else $error("lv reserved bits set");
  a_status_track: assert property (($stable(monitored_supply_low) [*5] ##0
    (reg_read && reg_addr == LOW_VOLTAGE_CONTROL_OFS)) |=> reg_rdata[LV_STATUS_BIT] == $past(monitored_supply_low))
    else $error("status does not follow supply");
  a_lv_raise: assert property (lv_en_reg && $changed(monitored_supply_low) |-> ##[1:5] supply_low_irq)
    else $error("supply change did not raise request");
  a_lv_hold: assert property (supply_low_irq && !lv_wr |=> supply_low_irq)
    else $error("lv flag dropped without clear");
  a_lv_gate: assert property (!lv_en_reg |-> !supply_low_irq)
    else $error("lv request while disabled");
  a_pt_hold: assert property (periodic_irq && !pt_wr |=> periodic_irq)
    else $error("timeout flag dropped without clear");
  a_pt_gate: assert property (!pt_ie_reg |-> !periodic_irq)
    else $error("timer request while disabled");
  a_pin_gate: assert property (!(feat_reg && pinen_reg) [*2] |-> !periodic_waveform_pin)
    else $error("pin driven while not enabled");
  c_lv_irq: cover property ($rose(supply_low_irq));
  c_pt_irq: cover property ($rose(periodic_irq));
  c_pin: cover property ($rose(periodic_waveform_pin));
endmodule

bind pitlv_timer pitlv_timer_props i_pitlv_timer_props (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .monitored_supply_low(monitored_supply_low), .nvm_trim_value(nvm_trim_value),
  .supply_low_irq(supply_low_irq), .periodic_irq(periodic_irq),
  .periodic_waveform_pin(periodic_waveform_pin));
`default_nettype wire

// ---- tb/pitlv_timer_tb_top.sv ----
// self-checking bench for the periodic timer and low-voltage block
`timescale 1ns/10ps
`default_nettype none
`define CK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; $display("mismatch %0t %h/%h", $time, a, e); end end
module pitlv_timer_tb_top;
  import pitlv_pkg::*;
  localparam logic [15:0] LV = LOW_VOLTAGE_CONTROL_OFS;
  localparam logic [15:0] CT = PERIODIC_TIMER_CONTROL_OFS;
  localparam logic [15:0] TR = PERIODIC_CLOCK_TRIM_OFS;
  localparam logic [15:0] RH = PERIODIC_RATE_HIGH_OFS;
  localparam logic [15:0] RL = PERIODIC_RATE_LOW_OFS;
  logic              clock, reset_n, reg_write, reg_read, sup_low, lv_irq, pt_irq, pin;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d, ctl;
  logic [TRIM_W-1:0] trim;
  logic [5:0]        trims[$];
  int                err_total, checks, seed, r, n, hi, per, tk;

  pitlv_timer i_pitlv_timer (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .monitored_supply_low(sup_low), .nvm_trim_value(trim), .supply_low_irq(lv_irq),
    .periodic_irq(pt_irq), .periodic_waveform_pin(pin));

  // ----------------------------------------
  // bus tasks; the idle edge after each strobe avoids a double drive
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [15:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic step(input logic s);
    @(posedge clock);
    #1;
    if (s) begin
      hi++;
    end else begin
      per++;
    end
  endtask
  // high time and rise-to-rise time of the pin; a pulse already high is skipped first
  task automatic span;
    n = 0;
    #1;
    while (pin === 1'b1 && n < 5000) begin
      @(posedge clock);
      #1 n++;
    end
    while (pin !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1 n++;
    end
    hi = 0;
    while (pin === 1'b1 && hi < 5000) step(1'b1);
    per = hi;
    while (pin !== 1'b1 && per < 5000) step(1'b0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #(100 * 60000);
    err_total++;
    results;
  end
  initial begin
    seed = 32'h56c6;
    err_total = 0;
    checks = 0;
    reset_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sup_low = 1'b0;
    trim = 6'($random(seed));
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(TR);
    `CK(d, {2'b00, trim})
    rd(16'h0000);
    `CK(d, 8'h00)
    wr(RH, 8'h5a);
    rd(RH);
    `CK(d, 8'h5a)
    $display("test registers done");
    // ----------------------------------------
    // supply monitor: both directions, then with request masked
    // ----------------------------------------
    wr(LV, 8'h02);
    for (int k = 0; k < 2; k++) begin
      sup_low <= ~sup_low;
      repeat (6) @(posedge clock);
      #1 `CK(lv_irq, 1'b1)
      rd(LV);
      `CK(d, {5'h00, sup_low, 2'b11})
      wr(LV, {5'h00, ~sup_low, 2'b10});
      rd(LV);
      `CK(d, {5'h00, sup_low, 2'b11})
      wr(LV, 8'h03);
      rd(LV);
      `CK(d, {5'h00, sup_low, 2'b10})
      #1 `CK(lv_irq, 1'b0)
    end
    wr(LV, 8'h00);
    sup_low <= ~sup_low;
    repeat (6) @(posedge clock);
    #1 `CK(lv_irq, 1'b0)
    rd(LV);
    `CK(d, {5'h00, sup_low, 2'b01})
    $display("test supply done");
    // ----------------------------------------
    // bus-clock timer, pulse then square, random rate
    // ----------------------------------------
    for (int w = 0; w < 2; w++) begin
      r = $random(seed) & 7;
      tk = 2 * (r + 1);
      ctl = {3'b100, w[0], 4'b1110};
      wr(CT, 8'h80);
      wr(RL, r[7:0]);
      wr(RH, 8'h00);
      wr(CT, ctl);
      n = 1;
      #1;
      while (pt_irq !== 1'b1 && n < 300) begin
        @(posedge clock);
        #1 n++;
      end
      `CK(n, tk)
      span;
      `CK(hi, w ? tk : 1)
      `CK(per, w ? 2 * tk : tk)
      wr(RL, 8'hff);
      rd(RL);
      `CK(d, r[7:0])
      wr(CT, ctl & 8'h7e);
      rd(CT);
      `CK(d, ctl | 8'h01)
      wr(CT, 8'h80);
      #1 `CK(pt_irq, 1'b0)
      wr(CT, 8'h83);
      rd(CT);
      `CK(d, 8'h82)
    end
    $display("test bus timer done");
    // ----------------------------------------
    // low-power source with trim, one lengthening and one shortening
    // ----------------------------------------
    // rate zero keeps the period at two ticks whatever the random rate left behind
    trims = {6'h20, 6'h01};
    wr(RL, 8'h00);
    foreach (trims[i]) begin
      tk = LP_BASE_CYCLES + 32 * LP_TRIM_STEP * trims[i][5] - LP_TRIM_STEP * trims[i][4:0];
      wr(TR, {2'b00, trims[i]});
      wr(CT, 8'h00);
      // clock select in the enabling write must not take effect
      wr(CT, 8'h8c);
      span;
      `CK(hi, tk)
      `CK(per, 2 * tk)
    end
    wr(CT, 8'h00);
    $display("test low-power timer done");
    results;
  end
endmodule
`default_nettype wire
